// *** src/acr_pkg.sv ***
// package: register map, field layout and types of the conversion clock and sequencer
package acr_pkg;

  // register byte offsets
  localparam logic [7:0] ACR_OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] ACR_OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] ACR_OFF_CTRL_THREE = 8'h08;
  localparam logic [7:0] ACR_OFF_STATUS = 8'h0C;

  // converter_control_one fields
  localparam int ACR_ONE_ENABLE_BIT = 0;
  localparam int ACR_ONE_TRIG_LSB = 1;
  localparam int ACR_ONE_AUTO_SAMPLE_BIT = 4;
  localparam int ACR_ONE_SIMUL_BIT = 5;
  localparam int ACR_ONE_SAMPLE_BIT = 6;
  // converter_control_two fields
  localparam int ACR_TWO_CH_COUNT_LSB = 0;
  localparam int ACR_TWO_CPI_LSB = 2;
  // converter_control_three fields
  localparam int ACR_THREE_DIV_LSB = 0;
  localparam int ACR_THREE_RC_BIT = 7;
  localparam int ACR_THREE_SAMPLE_TIME_LSB = 8;
  // status fields
  localparam int ACR_ST_CONVERTING_BIT = 0;
  localparam int ACR_ST_SAMPLING_BIT = 1;
  localparam int ACR_ST_DONE_BIT = 2;
  localparam int ACR_ST_CHANNEL_LSB = 4;
  localparam int ACR_ST_COUNT_LSB = 8;

  // writable bits per register, everything else reads zero except the sample bit of converter_control_one
  localparam logic [31:0] ACR_ONE_MASK = 32'h0000003F;
  localparam logic [31:0] ACR_TWO_MASK = 32'h0000003F;
  localparam logic [31:0] ACR_THREE_MASK = 32'h00001FBF;

  // reset values
  localparam logic [31:0] ACR_CTRL_ONE_RST = 32'h00000000;
  localparam logic [31:0] ACR_CTRL_TWO_RST = 32'h00000000;
  localparam logic [31:0] ACR_CTRL_THREE_RST = 32'h00000000;

  // trigger encodings and timing
  localparam logic [2:0] ACR_TRIG_SOFTWARE = 3'h0;
  localparam logic [2:0] ACR_TRIG_AUTO = 3'h7;
  localparam logic [4:0] ACR_CONV_TAD_COUNT = 5'h0C;
  localparam int ACR_INSTR_CYCLE_NS = 25;
  localparam logic [6:0] ACR_HALF_CYCLES_PER_CLK = 7'h02;

  // axi response codes
  localparam logic [1:0] ACR_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ACR_IDLE, ACR_SAMPLE, ACR_CONVERT} acr_state_e;

  typedef struct packed {
    logic enable;
    logic [2:0] trigger_source_select;
    logic auto_sample_enable;
    logic simultaneous_sample_select;
    logic [1:0] sh_channel_count;
    logic [3:0] conversions_per_interrupt;
    logic [5:0] conv_clock_divisor;
    logic rc_clock_select;
    logic [4:0] auto_sample_time;
  } acr_cfg_s;

endpackage

// *** src/acr_top.sv ***
// conversion clock generator, sample/convert sequencer and axi4-lite register slave
// Functional notes
// R01 - one conversion takes exactly twelve conversion clock periods after sampling
// R02 - conversion period is instruction cycle times half of divisor plus one
// R03 - rc select bit takes conversion clock from the rc oscillator instead
// R04 - software keeps the conversion period at or above 83.33 ns
// R05 - trigger select 111 starts conversion when the sample time expires
// R06 - auto-sample enable restarts sampling by itself after the last conversion of each channel group
// R07 - simultaneous select clear samples enabled channels one after another
// R08 - channel count 00 enables exactly one sample-and-hold channel
// R09 - sample time field counts conversion periods; 00010 gives two
// R10 - software sets conversions per event to at least 0001 with two channels
// R11 - conversions-per-event field sets conversions between successive events
// R12 - one channel converts while the other channel acquires the next sample
// R13 - software picks sequential sampling when inputs share the top rate
// R14 - software picks auto convert, auto sample, sequential, two channels for top rate
// R15 - software allows fourteen periods per sample with one channel at 750 ksps
// R16 - sample time never acts below one conversion period
// R17 - channel count selects one, two or four channels from channel zero upward
// R18 - a reload counter driven by the divisor produces the conversion clock
`timescale 1ns/10ps
`default_nettype none
module acr_top
  import acr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rc_osc_in,
  input wire logic ext_trigger,
  output logic tad_tick,
  output logic [3:0] sh_sample,
  output logic conv_active,
  output logic [1:0] conv_channel,
  output logic conv_done,
  output logic sequence_event
);

  // enabled channel mask for a channel count code
  function automatic logic [3:0] ch_mask(input logic [1:0] cnt);
    ch_mask = (cnt == 2'h0) ? 4'h1 : (cnt == 2'h1) ? 4'h3 : 4'hF;
  endfunction

  // one-hot of a channel index
  function automatic logic [3:0] ch_onehot(input logic [1:0] ch);
    ch_onehot = 4'h1 << ch;
  endfunction

  // byte-lane merge restricted to writable bits
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb, input logic [31:0] m);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & m;
    wmerge = (old & ~lanes) | (d & lanes);
  endfunction

  logic [31:0] ctrl_one_reg;
  logic [31:0] ctrl_two_reg;
  logic [31:0] ctrl_three_reg;
  logic samp_reg;
  logic done_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic rc_s1_reg;
  logic rc_s2_reg;
  logic rc_s3_reg;
  logic rc_level_reg;
  logic [6:0] half_acc_reg;
  acr_state_e state_reg;
  logic [4:0] tad_cnt_reg;
  logic [1:0] ch_reg;
  logic [3:0] conv_cnt_reg;
  acr_cfg_s cfg;

  // decoded configuration
  assign cfg.enable = ctrl_one_reg[ACR_ONE_ENABLE_BIT];
  assign cfg.trigger_source_select = ctrl_one_reg[ACR_ONE_TRIG_LSB +: 3];
  assign cfg.auto_sample_enable = ctrl_one_reg[ACR_ONE_AUTO_SAMPLE_BIT];
  assign cfg.simultaneous_sample_select = ctrl_one_reg[ACR_ONE_SIMUL_BIT];
  assign cfg.sh_channel_count = ctrl_two_reg[ACR_TWO_CH_COUNT_LSB +: 2];
  assign cfg.conversions_per_interrupt = ctrl_two_reg[ACR_TWO_CPI_LSB +: 4];
  assign cfg.conv_clock_divisor = ctrl_three_reg[ACR_THREE_DIV_LSB +: 6];
  assign cfg.rc_clock_select = ctrl_three_reg[ACR_THREE_RC_BIT];
  assign cfg.auto_sample_time = ctrl_three_reg[ACR_THREE_SAMPLE_TIME_LSB +: 5];

  // bus decode; an address is held until its data arrives and the response is taken
  wire aw_held = ~s_axi_awready;
  wire w_held = ~s_axi_wready;
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire wr_one = wr_fire & (aw_addr_reg == ACR_OFF_CTRL_ONE);
  wire wr_two = wr_fire & (aw_addr_reg == ACR_OFF_CTRL_TWO);
  wire wr_three = wr_fire & (aw_addr_reg == ACR_OFF_CTRL_THREE);
  wire wr_status = wr_fire & (aw_addr_reg == ACR_OFF_STATUS);
  wire wr_ok = wr_one | wr_two | wr_three | wr_status;
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire rd_ok = (rd_addr == ACR_OFF_CTRL_ONE) | (rd_addr == ACR_OFF_CTRL_TWO) |
               (rd_addr == ACR_OFF_CTRL_THREE) | (rd_addr == ACR_OFF_STATUS);
  wire [31:0] status_word = ({31'h0, state_reg == ACR_CONVERT} << ACR_ST_CONVERTING_BIT) |
                            ({31'h0, state_reg == ACR_SAMPLE} << ACR_ST_SAMPLING_BIT) |
                            ({31'h0, done_reg} << ACR_ST_DONE_BIT) |
                            ({30'h0, ch_reg} << ACR_ST_CHANNEL_LSB) |
                            ({28'h0, conv_cnt_reg} << ACR_ST_COUNT_LSB);
  wire [31:0] rd_word = (rd_addr == ACR_OFF_CTRL_ONE) ?
                          (ctrl_one_reg | ({31'h0, samp_reg} << ACR_ONE_SAMPLE_BIT)) :
                        (rd_addr == ACR_OFF_CTRL_TWO) ? ctrl_two_reg :
                        (rd_addr == ACR_OFF_CTRL_THREE) ? ctrl_three_reg :
                        (rd_addr == ACR_OFF_STATUS) ? status_word : 32'h00000000;

  // write channel: address and data accepted in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ACR_RESP_OKAY;
      aw_addr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? ACR_RESP_OKAY : ACR_RESP_SLVERR; // unmapped: slave error
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: one read in flight, data one cycle after the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ACR_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? ACR_RESP_OKAY : ACR_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // configuration registers; rewriting them mid-sequence is software's hazard
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_one_reg <= ACR_CTRL_ONE_RST;
      ctrl_two_reg <= ACR_CTRL_TWO_RST;
      ctrl_three_reg <= ACR_CTRL_THREE_RST;
    end
    else
    begin
      if (wr_one)
        ctrl_one_reg <= wmerge(ctrl_one_reg, wdata_reg, wstrb_reg, ACR_ONE_MASK);
      if (wr_two)
        ctrl_two_reg <= wmerge(ctrl_two_reg, wdata_reg, wstrb_reg, ACR_TWO_MASK);
      if (wr_three)
        ctrl_three_reg <= wmerge(ctrl_three_reg, wdata_reg, wstrb_reg, ACR_THREE_MASK);
    end
  end

  // rc oscillator pin: three stages, a level counts once stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_s3_reg <= 1'b0;
      rc_level_reg <= 1'b0;
    end
    else
    begin
      rc_s1_reg <= rc_osc_in;
      rc_s2_reg <= rc_s1_reg;
      rc_s3_reg <= rc_s2_reg;
      if (rc_s2_reg == rc_s3_reg)
        rc_level_reg <= rc_s3_reg;
    end
  end

  // divided clock in half-instruction-cycle units; divisor 0 caps at one tick per cycle
  wire rc_rise = rc_s2_reg & rc_s3_reg & ~rc_level_reg;
  wire [6:0] div_plus1 = {1'b0, cfg.conv_clock_divisor} + 7'h01;
  wire [6:0] half_sum = half_acc_reg + ACR_HALF_CYCLES_PER_CLK;
  wire div_hit = (half_sum >= div_plus1); // [R02]
  wire [6:0] half_rem = (div_plus1 < ACR_HALF_CYCLES_PER_CLK) ? 7'h00 : half_sum - div_plus1;
  wire tick_next = cfg.enable & (cfg.rc_clock_select ? rc_rise : div_hit); // [R03]

  // reload counter and registered tick; the tick is the single slow-rate enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !cfg.enable)
    begin
      half_acc_reg <= 7'h00;
      tad_tick <= 1'b0;
    end
    else
    begin
      half_acc_reg <= div_hit ? half_rem : half_sum; // [R18]
      tad_tick <= tick_next;
    end
  end

  // sequencer decode
  wire [1:0] last_ch = (cfg.sh_channel_count == 2'h0) ? 2'h0 :
                       (cfg.sh_channel_count == 2'h1) ? 2'h1 : 2'h3; // [R08] [R17]
  wire [3:0] en_mask = ch_mask(cfg.sh_channel_count); // [R17]
  wire [4:0] samp_time = (cfg.auto_sample_time == 5'h00) ? 5'h01 : cfg.auto_sample_time; // [R16]
  wire auto_go = tad_tick & (tad_cnt_reg + 5'h01 >= samp_time); // [R09]
  wire trig_go = (cfg.trigger_source_select == ACR_TRIG_AUTO) ? auto_go : // [R05]
                 (cfg.trigger_source_select == ACR_TRIG_SOFTWARE) ? ~samp_reg : ext_trigger;
  wire conv_end = (state_reg == ACR_CONVERT) & tad_tick &
                  (tad_cnt_reg + 5'h01 == ACR_CONV_TAD_COUNT); // [R01]
  wire group_end = conv_end & (ch_reg == last_ch);
  wire event_hit = conv_end & (conv_cnt_reg == cfg.conversions_per_interrupt); // [R11]
  wire hw_set_samp = conv_end & (~group_end & ~cfg.simultaneous_sample_select |
                                 group_end & cfg.auto_sample_enable); // [R06]
  wire hw_clr_samp = group_end & ~cfg.auto_sample_enable;
  wire sw_samp = wr_one & wstrb_reg[0];

  // sample request bit: a hardware set wins over a software clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      samp_reg <= 1'b0;
    else if (hw_set_samp)
      samp_reg <= 1'b1;
    else if (sw_samp)
      samp_reg <= wdata_reg[ACR_ONE_SAMPLE_BIT];
    else if (hw_clr_samp)
      samp_reg <= 1'b0;
  end

  // done flag: set on every event, write one to clear, set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done_reg <= 1'b0;
    else if (event_hit)
      done_reg <= 1'b1;
    else if (wr_status && wstrb_reg[0] && wdata_reg[ACR_ST_DONE_BIT])
      done_reg <= 1'b0;
  end

  // sample/convert state machine; disabling aborts at once
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !cfg.enable)
    begin
      state_reg <= ACR_IDLE;
      tad_cnt_reg <= 5'h00;
      ch_reg <= 2'h0;
      conv_cnt_reg <= 4'h0;
    end
    else
    begin
      case (state_reg)
        ACR_IDLE:
        begin
          tad_cnt_reg <= 5'h00;
          if (samp_reg)
            state_reg <= ACR_SAMPLE;
        end
        ACR_SAMPLE:
        begin
          if (trig_go)
          begin
            state_reg <= ACR_CONVERT;
            tad_cnt_reg <= 5'h00;
          end
          else if (tad_tick)
            tad_cnt_reg <= tad_cnt_reg + 5'h01;
        end
        ACR_CONVERT:
        begin
          if (conv_end)
          begin
            tad_cnt_reg <= 5'h00;
            conv_cnt_reg <= event_hit ? 4'h0 : conv_cnt_reg + 4'h1;
            ch_reg <= group_end ? 2'h0 : ch_reg + 2'h1;
            // simultaneous groups already hold every channel, so convert straight on
            if (!group_end && cfg.simultaneous_sample_select)
              state_reg <= ACR_CONVERT;
            else if (!group_end || cfg.auto_sample_enable)
              state_reg <= ACR_SAMPLE; // [R07] [R06]
            else
              state_reg <= ACR_IDLE;
          end
          else if (tad_tick)
            tad_cnt_reg <= tad_cnt_reg + 5'h01;
        end
        default:
          state_reg <= ACR_IDLE;
      endcase
    end
  end

  // hold channel drive: sequential mode lets the others acquire during a conversion
  wire [3:0] sample_next = (state_reg == ACR_SAMPLE) ?
                             (cfg.simultaneous_sample_select ? en_mask : ch_onehot(ch_reg)) :
                           (state_reg == ACR_CONVERT && !cfg.simultaneous_sample_select) ?
                             (en_mask & ~ch_onehot(ch_reg)) : 4'h0; // [R12] [R07]

  // registered status outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sh_sample <= 4'h0;
      conv_active <= 1'b0;
      conv_channel <= 2'h0;
      conv_done <= 1'b0;
      sequence_event <= 1'b0;
    end
    else
    begin
      sh_sample <= sample_next;
      conv_active <= (state_reg == ACR_CONVERT) & ~conv_end;
      conv_channel <= ch_reg;
      conv_done <= conv_end;
      sequence_event <= event_hit; // [R11]
    end
  end

endmodule // acr_top
`default_nettype wire

// *** verif/acr_props.sv ***
// checker: port properties of the conversion clock block
`timescale 1ns/10ps
`default_nettype none
module acr_props
  import acr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic tad_tick,
  input wire logic [3:0] sh_sample,
  input wire logic conv_active,
  input wire logic [1:0] conv_channel,
  input wire logic conv_done,
  input wire logic sequence_event
);
  logic [4:0] tick_cnt_reg;
  logic [4:0] tick_cnt_next;
  logic tick_in_conv;

  // ticks of the running conversion; cleared when idle so an abort leaves no residue
  assign tick_in_conv = tad_tick && conv_active;
  assign tick_cnt_next = (conv_done || !conv_active) ? {4'h0, tick_in_conv}
                                                     : tick_cnt_reg + {4'h0, tick_in_conv};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_cnt_reg <= 5'h00;
    else
      tick_cnt_reg <= tick_cnt_next;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // write answer comes two edges after both halves are taken
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer open");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0C
    |=> s_axi_rresp == ACR_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_conv_length: assert property (conv_done |-> tick_cnt_reg == ACR_CONV_TAD_COUNT)
    else $error("conversion length wrong");
  a_done_cause: assert property (conv_done |-> $past(tad_tick) && $past(conv_active))
    else $error("done without closing tick");
  a_hold_apart: assert property (conv_active |-> !sh_sample[conv_channel])
    else $error("converted channel still acquiring");
  a_event_on_done: assert property (sequence_event |-> conv_done || $past(conv_done))
    else $error("event without conversion");
endmodule // acr_props
`default_nettype wire

// *** verif/acr_top_test.sv ***
// testbench: registers and sequencing of the conversion clock block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
module acr_top_test;
  import acr_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] strb;
    logic [31:0] data;
    logic [31:0] rexp;
    logic [1:0] resp;
  } acr_row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  // answers are always accepted at once
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic rc_osc_in = 1'b0;
  logic ext_trigger = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, conv_channel, resp;
  logic [31:0] s_axi_rdata, rd_data;
  logic tad_tick, conv_active, conv_done, sequence_event;
  logic [3:0] sh_sample, first_pat, all_pat;
  logic mon = 1'b0;
  int errors = 0;
  int checked = 0;
  int ticks, rticks, dones, events, cyc, last, gap_lo, gap_hi;
  logic [7:0] offs [3] = '{ACR_OFF_CTRL_ONE, ACR_OFF_CTRL_TWO, ACR_OFF_CTRL_THREE};
  acr_row_s rows [8] = '{
    '{8'h00, 4'hF, 32'hFFFFFFBE, 32'h0000003E, ACR_RESP_OKAY},
    '{8'h00, 4'hF, 32'h00000000, 32'h00000000, ACR_RESP_OKAY},
    '{8'h04, 4'hF, 32'hFFFFFFFF, 32'h0000003F, ACR_RESP_OKAY},
    '{8'h04, 4'hF, 32'h00000000, 32'h00000000, ACR_RESP_OKAY},
    '{8'h08, 4'h1, 32'hFFFFFFFF, 32'h000000BF, ACR_RESP_OKAY},
    '{8'h08, 4'h2, 32'hFFFFFFFF, 32'h00001FBF, ACR_RESP_OKAY},
    '{8'h08, 4'hF, 32'h00000000, 32'h00000000, ACR_RESP_OKAY},
    '{8'h10, 4'hF, 32'hFFFFFFFF, 32'h00000000, ACR_RESP_SLVERR}};

  acr_top i_dut (.*);

  initial
  begin
    forever #12.5 aclk = ~aclk;
  end

  // monitor sees registered outputs as they stood before each edge
  always @(posedge aclk)
  begin
    cyc++;
    if (mon)
    begin
      rticks += tad_tick;
      dones += conv_done;
      events += sequence_event;
      if (first_pat == 4'h0)
        first_pat = sh_sample;
      all_pat |= sh_sample;
      if (tad_tick && (sh_sample != 4'h0 || conv_active))
      begin
        ticks++;
        if (ticks > 1)
          gap_lo = (cyc - last < gap_lo) ? cyc - last : gap_lo;
        if (ticks > 1)
          gap_hi = (cyc - last > gap_hi) ? cyc - last : gap_hi;
        last = cyc;
      end
    end
  end

  // write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    resp = s_axi_bresp;
    errors += (n >= 100);
  endtask

  task automatic rd(input logic [7:0] a);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    errors += (n >= 100);
  endtask

  // configure, start and watch until n conversions finished, then switch off
  task automatic run(input logic [31:0] c3, input logic [31:0] c2, input logic [31:0] c1,
                     input int n);
    int k = 0;
    wr(ACR_OFF_CTRL_THREE, c3);
    wr(ACR_OFF_CTRL_TWO, c2);
    {ticks, dones, events, gap_hi, first_pat, all_pat} = '0;
    gap_lo = 1000;
    mon = 1'b1;
    wr(ACR_OFF_CTRL_ONE, c1);
    while (dones < n && k < 3000)
    begin
      @(posedge aclk);
      k++;
    end
    mon = 1'b0;
    errors += (k >= 3000);
    rd(ACR_OFF_CTRL_ONE);
    wr(ACR_OFF_CTRL_ONE, 32'h0);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog well beyond the expected run of under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    complete_run();
  end

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i])
    begin
      s_axi_wstrb <= rows[i].strb;
      wr(rows[i].addr, rows[i].data);
      `CHK("bresp", rows[i].resp, resp);
      rd(rows[i].addr);
      `CHK("rdata", rows[i].rexp, rd_data);
      `CHK("rresp", rows[i].resp, resp);
    end
    s_axi_wstrb <= 4'hF;
    $display("table done");
    // one channel, 100 ns period, two periods of sampling, no restart
    run(32'h00000207, 32'h00000000, 32'h0000004F, 1);
    `CHK("ticks", 14, ticks);
    `CHK("gap_lo", 4, gap_lo);
    `CHK("gap_hi", 4, gap_hi);
    `CHK("single", 4'h1, all_pat);
    `CHK("ctrl", 32'h0000000F, rd_data);
    $display("single done");
    // two channels in turn, restarting by itself, event every second conversion
    run(32'h00000207, 32'h00000005, 32'h0000005F, 5);
    `CHK("events", 2, events);
    `CHK("first", 4'h1, first_pat);
    `CHK("chans", 4'h3, all_pat);
    $display("sequential done");
    // four channels sampled together
    run(32'h00000207, 32'h0000000E, 32'h0000007F, 5);
    `CHK("first", 4'hF, first_pat);
    `CHK("events", 1, events);
    $display("simultaneous done");
    // oscillator source: nothing while the pin rests, one tick per rising edge
    wr(ACR_OFF_CTRL_THREE, 32'h00000080);
    wr(ACR_OFF_CTRL_ONE, 32'h00000001);
    rticks = 0;
    mon = 1'b1;
    repeat (40) @(posedge aclk);
    `CHK("rc idle", 0, rticks);
    repeat (5)
    begin
      repeat (4) @(posedge aclk);
      rc_osc_in <= 1'b1;
      repeat (4) @(posedge aclk);
      rc_osc_in <= 1'b0;
    end
    repeat (8) @(posedge aclk);
    mon = 1'b0;
    `CHK("rc ticks", 5, rticks);
    wr(ACR_OFF_CTRL_ONE, 32'h0);
    $display("rc done");
    // reset in mid-sequence clears registers and stops the sequencer
    run(32'h00000207, 32'h00000001, 32'h0000005F, 1);
    wr(ACR_OFF_CTRL_ONE, 32'h0000005F);
    repeat (30) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("active", 1'b0, conv_active);
    `CHK("sampling", 4'h0, sh_sample);
    foreach (offs[i])
    begin
      rd(offs[i]);
      `CHK("reset reg", 32'h0, rd_data);
    end
    $display("reset done");
    // software trigger: clearing the sample bit starts one conversion; done clears on write
    wr(ACR_OFF_CTRL_THREE, 32'h00000207);
    wr(ACR_OFF_CTRL_ONE, 32'h00000041);
    repeat (20) @(posedge aclk);
    rd(ACR_OFF_STATUS);
    `CHK("sampling", 32'h00000002, rd_data);
    dones = 0;
    mon = 1'b1;
    wr(ACR_OFF_CTRL_ONE, 32'h00000001);
    repeat (200) @(posedge aclk);
    mon = 1'b0;
    `CHK("sw dones", 1, dones);
    rd(ACR_OFF_STATUS);
    `CHK("status done", 32'h00000004, rd_data);
    wr(ACR_OFF_STATUS, 32'h00000004);
    rd(ACR_OFF_STATUS);
    `CHK("done clear", 32'h00000000, rd_data);
    wr(ACR_OFF_CTRL_ONE, 32'h0);
    $display("software trigger done");
    complete_run();
  end
endmodule // acr_top_test
bind acr_top acr_props i_props (.*);
`default_nettype wire
